// File: qr_flyback_pkg.sv
// Constants for the quasi-resonant flyback drive and protection logic.
// Assumes a 50 MHz core clock; times are kept in their own units and converted here.
package qr_flyback_pkg;
    localparam int CLOCK_PERIOD_NS = 20;
    localparam int CLOCK_RATE_HZ = 50000000;
    // Valley timeouts are longest times, so they round down
    localparam int STEADY_TIMEOUT_NS = 6000;
    localparam int STEADY_TIMEOUT_CYC = STEADY_TIMEOUT_NS / CLOCK_PERIOD_NS;
    localparam int STARTUP_TIMEOUT_US = 100;
    localparam int STARTUP_TIMEOUT_CYC = STARTUP_TIMEOUT_US * (CLOCK_RATE_HZ / 1000000);
    // Blanking intervals are least times, so they round up
    localparam int PRIMARY_BLANK_NS = 275;
    localparam int PRIMARY_BLANK_CYC = (PRIMARY_BLANK_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int SHORT_BLANK_NS = 120;
    localparam int SHORT_BLANK_CYC = (SHORT_BLANK_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int OVERLOAD_EXPIRY_MS = 80;
    localparam int OVERLOAD_EXPIRY_CYC = OVERLOAD_EXPIRY_MS * (CLOCK_RATE_HZ / 1000);
    localparam int RAMP_DURATION_MS = 4;
    localparam int RAMP_DURATION_CYC = RAMP_DURATION_MS * (CLOCK_RATE_HZ / 1000);
    // Ramp reference code; full scale stands for the normal peak threshold
    localparam int RAMP_WIDTH = 8;
    localparam logic [7:0] RAMP_RESET = 8'h00;
    localparam logic [7:0] PEAK_THRESHOLD_CODE = 8'hff;
    localparam int SEVERE_LATCH_COUNT = 4;
    localparam int HICCUP_RESTART_COUNT = 3;
    localparam int TIMER_WIDTH = 23;
    localparam int SYNC_WIDTH = 8;
    // Bit positions in the synchronised comparator vector
    localparam int BIT_DEMAG = 0;
    localparam int BIT_PWM = 1;
    localparam int BIT_PEAK = 2;
    localparam int BIT_SEVERE = 3;
    localparam int BIT_RAMP = 4;
    localparam int BIT_OTP = 5;
    localparam int BIT_BROWN = 6;
    localparam int BIT_HICCUP = 7;
    typedef enum logic [1:0] {
        ST_OFF = 2'b00,
        ST_ON = 2'b01,
        ST_HICCUP = 2'b11,
        ST_LATCHED = 2'b10
    } drive_state_type;
endpackage

// File: comparator_sync.sv
// Two-flop synchroniser for the asynchronous comparator outputs.
// Assumes each input is a level; only the second stage may be used downstream.
`timescale 1ns/10ps
`default_nettype none
module comparator_sync (
    input wire logic clock,                                    // Core clock
    input wire logic reset_n,                                  // Async reset, active low
    input wire logic [qr_flyback_pkg::SYNC_WIDTH-1:0] rawIn,   // Raw comparator levels
    output logic [qr_flyback_pkg::SYNC_WIDTH-1:0] syncOut      // Synchronised levels
);
    import qr_flyback_pkg::*;

    logic [SYNC_WIDTH-1:0] stage1_ff;
    logic [SYNC_WIDTH-1:0] stage2_ff;

    genvar i;
    generate
        for (i = 0; i < SYNC_WIDTH; i++) begin : g_bit
            always_ff @(posedge clock or negedge reset_n) begin
                if (!reset_n) begin
                    stage1_ff[i] <= 1'b0;
                    stage2_ff[i] <= 1'b0;
                end else begin
                    stage1_ff[i] <= rawIn[i];
                    stage2_ff[i] <= stage1_ff[i];
                end
            end
        end
    endgenerate

    assign syncOut = stage2_ff;
endmodule // comparator_sync
`default_nettype wire

// File: qr_flyback_drive.sv
// Drive timing and protection for a quasi-resonant flyback switch.
// Assumes comparator outputs arrive asynchronously and a filtered fault, brown-out and
// supply-hiccup indication come from neighbouring analog blocks.
// Functional notes
// - Missing demag event within timeout produces a substitute valley event.
// - Outside soft-start the valley timeout is 6 us.
// - During soft-start the valley timeout is 100 us.
// - Ignore PWM and peak comparisons for 275 ns after turn-on.
// - After blanking, PWM comparison ends the drive pulse.
// - Peak comparison above 0.8 V ends the pulse and enables overload timer.
// - Overload timer counts up during overload, down otherwise; expires at 80 ms.
// - Simultaneous PWM and peak trips count as PWM; timer counts down.
// - On expiry stop switching, then latch or auto-recover per build option.
// - Auto-recovery restarts only after three supply hiccup cycles.
// - Severe overcurrent at 1.2 V evaluated after 120 ns blanking.
// - Four severe trips in consecutive pulses latch the drive off.
// - A pulse without severe trip clears the severe counter.
// - Soft-start ramp reference rises from zero over 4 ms, limiting current.
// - Overtemperature fault is ignored during soft-start.
// - Soft-start ends when ramp reaches peak threshold code, restoring short timeout.
// - Latched-off clears only on brown-out or supply reset.
`timescale 1ns/10ps
`default_nettype none
module qr_flyback_drive #(
    parameter int STARTUP_TIMEOUT = qr_flyback_pkg::STARTUP_TIMEOUT_CYC,   // Soft-start valley timeout
    parameter int OVERLOAD_EXPIRY = qr_flyback_pkg::OVERLOAD_EXPIRY_CYC,   // Overload timer expiry
    parameter int RAMP_DURATION = qr_flyback_pkg::RAMP_DURATION_CYC,       // Soft-start ramp length
    parameter bit LATCH_ON_OVERLOAD = 1'b1                                 // 1 latch, 0 auto-recover
) (
    input wire logic clock,                            // 50 MHz core clock
    input wire logic reset_n,                          // Supply reset, async, active low
    input wire logic demagDetectIn,                    // Demag / valley comparator
    input wire logic pwmTripIn,                        // Sense above scaled feedback level
    input wire logic peakTripIn,                       // Sense above peak limit reference
    input wire logic severeTripIn,                     // Sense above severe limit reference
    input wire logic rampTripIn,                       // Sense above ramp reference
    input wire logic overTempIn,                       // Filtered lower fault detection
    input wire logic brownOutIn,                       // Brown-out detected
    input wire logic hiccupDoneIn,                     // Supply completed one hiccup cycle
    output logic switchDriveOut,                       // Switch drive pulse
    output logic valleyEventOut,                       // Valley or timeout event, one cycle
    output logic [qr_flyback_pkg::RAMP_WIDTH-1:0] rampReference, // Soft-start ramp code
    output logic softStartActive,                      // Soft-start in progress
    output logic latchedOff                            // Latched off
);
    import qr_flyback_pkg::*;

    localparam int RAMP_STEP = RAMP_DURATION / (1 << RAMP_WIDTH);
    localparam logic [TIMER_WIDTH-1:0] STEADY_LIMIT = TIMER_WIDTH'(STEADY_TIMEOUT_CYC - 1);
    localparam logic [TIMER_WIDTH-1:0] STARTUP_LIMIT = TIMER_WIDTH'(STARTUP_TIMEOUT - 1);
    localparam logic [TIMER_WIDTH-1:0] OVERLOAD_LIMIT = TIMER_WIDTH'(OVERLOAD_EXPIRY - 1);
    localparam logic [TIMER_WIDTH-1:0] RAMP_STEP_LIMIT = TIMER_WIDTH'(RAMP_STEP - 1);
    localparam logic [7:0] LEB1 = 8'(PRIMARY_BLANK_CYC);
    localparam logic [7:0] LEB2 = 8'(SHORT_BLANK_CYC);
    localparam logic [2:0] SEVERE_LIMIT = 3'(SEVERE_LATCH_COUNT);
    localparam logic [1:0] HICCUP_LIMIT = 2'(HICCUP_RESTART_COUNT);

    logic [SYNC_WIDTH-1:0] rawVec;
    logic [SYNC_WIDTH-1:0] syncVec;

    drive_state_type state_ff, nxt_state;
    logic [TIMER_WIDTH-1:0] timeout_ff, nxt_timeout;
    logic [TIMER_WIDTH-1:0] overload_ff, nxt_overload;
    logic [TIMER_WIDTH-1:0] rampTick_ff, nxt_rampTick;
    logic [RAMP_WIDTH-1:0] ramp_ff, nxt_ramp;
    logic [7:0] onCount_ff, nxt_onCount;
    logic [2:0] severeCount_ff, nxt_severeCount;
    logic [1:0] hiccupCount_ff, nxt_hiccupCount;
    logic overloadSeen_ff, nxt_overloadSeen;
    logic softStart_ff, nxt_softStart;
    logic demagPrev_ff, nxt_demagPrev;
    logic hiccupPrev_ff, nxt_hiccupPrev;
    logic drive_ff, nxt_drive;
    logic valley_ff, nxt_valley;

    logic demagRise;
    logic hiccupRise;
    logic timeoutHit;
    logic valleyEvt;
    logic endPwm;
    logic endPeak;
    logic severeHit;
    logic pulseEnd;

    assign rawVec = {hiccupDoneIn, brownOutIn, overTempIn, rampTripIn,
                     severeTripIn, peakTripIn, pwmTripIn, demagDetectIn};

    comparator_sync u_sync (
        .clock(clock),
        .reset_n(reset_n),
        .rawIn(rawVec),
        .syncOut(syncVec)
    );

    always_comb begin
        nxt_state = state_ff;
        nxt_overload = overload_ff;
        nxt_onCount = onCount_ff;
        nxt_severeCount = severeCount_ff;
        nxt_hiccupCount = hiccupCount_ff;
        nxt_overloadSeen = overloadSeen_ff;
        nxt_ramp = ramp_ff;
        nxt_rampTick = rampTick_ff;
        nxt_softStart = softStart_ff;
        nxt_demagPrev = syncVec[BIT_DEMAG];
        nxt_hiccupPrev = syncVec[BIT_HICCUP];
        demagRise = syncVec[BIT_DEMAG] && !demagPrev_ff;
        hiccupRise = syncVec[BIT_HICCUP] && !hiccupPrev_ff;

        timeoutHit = softStart_ff ? (timeout_ff >= STARTUP_LIMIT) : (timeout_ff >= STEADY_LIMIT);
        // timeout stands in for a valley
        valleyEvt = demagRise || timeoutHit;
        nxt_timeout = valleyEvt ? '0 : timeout_ff + 1'b1;
        nxt_valley = valleyEvt;

        endPwm = (state_ff == ST_ON) && (onCount_ff >= LEB1) && syncVec[BIT_PWM];
        endPeak = (state_ff == ST_ON) && (onCount_ff >= LEB1)
                  && (syncVec[BIT_PEAK] || (softStart_ff && syncVec[BIT_RAMP]));
        severeHit = (state_ff == ST_ON) && (onCount_ff >= LEB2) && syncVec[BIT_SEVERE];
        pulseEnd = endPwm || endPeak || severeHit;

        // ramp steps up to the threshold code
        if (softStart_ff) begin
            if (rampTick_ff >= RAMP_STEP_LIMIT) begin
                nxt_rampTick = '0;
                nxt_ramp = ramp_ff + 1'b1;
            end else begin
                nxt_rampTick = rampTick_ff + 1'b1;
            end
        end
        if (softStart_ff && ramp_ff == PEAK_THRESHOLD_CODE) begin
            nxt_softStart = 1'b0;
        end

        if (overloadSeen_ff) begin
            if (overload_ff != OVERLOAD_LIMIT) begin
                nxt_overload = overload_ff + 1'b1;
            end
        end else if (overload_ff != '0) begin
            nxt_overload = overload_ff - 1'b1;
        end

        case (state_ff)
            ST_OFF: begin
                if (valleyEvt) begin
                    nxt_state = ST_ON;
                    nxt_onCount = '0;
                end
            end
            ST_ON: begin
                if (onCount_ff != 8'hff) begin
                    nxt_onCount = onCount_ff + 1'b1;
                end
                if (pulseEnd) begin
                    nxt_state = ST_OFF;
                    nxt_overloadSeen = endPeak && syncVec[BIT_PEAK] && !endPwm;
                    if (severeHit) begin
                        nxt_severeCount = severeCount_ff + 1'b1;
                        if (severeCount_ff + 1'b1 == SEVERE_LIMIT) begin
                            nxt_state = ST_LATCHED;
                        end
                    end else begin
                        nxt_severeCount = '0;
                    end
                end
            end
            ST_HICCUP: begin
                if (hiccupRise) begin
                    nxt_hiccupCount = hiccupCount_ff + 1'b1;
                    if (hiccupCount_ff + 1'b1 == HICCUP_LIMIT) begin
                        nxt_state = ST_OFF;
                        nxt_hiccupCount = '0;
                        nxt_overload = '0;
                        nxt_overloadSeen = 1'b0;
                        nxt_softStart = 1'b1;
                        nxt_ramp = RAMP_RESET;
                        nxt_rampTick = '0;
                    end
                end
            end
            ST_LATCHED: begin
                if (syncVec[BIT_BROWN]) begin
                    nxt_state = ST_OFF;
                    nxt_severeCount = '0;
                    nxt_overload = '0;
                    nxt_overloadSeen = 1'b0;
                    nxt_softStart = 1'b1;
                    nxt_ramp = RAMP_RESET;
                    nxt_rampTick = '0;
                end
            end
            default: begin
                nxt_state = ST_OFF;
            end
        endcase

        if ((state_ff == ST_OFF || state_ff == ST_ON) && overloadSeen_ff && overload_ff == OVERLOAD_LIMIT) begin
            nxt_state = LATCH_ON_OVERLOAD ? ST_LATCHED : ST_HICCUP;
            nxt_hiccupCount = '0;
        end
        if (!softStart_ff && syncVec[BIT_OTP] && state_ff != ST_HICCUP) begin
            nxt_state = ST_LATCHED;
        end
        nxt_drive = (nxt_state == ST_ON);
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state_ff <= ST_OFF;
            timeout_ff <= '0;
            overload_ff <= '0;
            rampTick_ff <= '0;
            ramp_ff <= RAMP_RESET;
            onCount_ff <= '0;
            severeCount_ff <= '0;
            hiccupCount_ff <= '0;
            overloadSeen_ff <= 1'b0;
            softStart_ff <= 1'b1;
            demagPrev_ff <= 1'b0;
            hiccupPrev_ff <= 1'b0;
            drive_ff <= 1'b0;
            valley_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            timeout_ff <= nxt_timeout;
            overload_ff <= nxt_overload;
            rampTick_ff <= nxt_rampTick;
            ramp_ff <= nxt_ramp;
            onCount_ff <= nxt_onCount;
            severeCount_ff <= nxt_severeCount;
            hiccupCount_ff <= nxt_hiccupCount;
            overloadSeen_ff <= nxt_overloadSeen;
            softStart_ff <= nxt_softStart;
            demagPrev_ff <= nxt_demagPrev;
            hiccupPrev_ff <= nxt_hiccupPrev;
            drive_ff <= nxt_drive;
            valley_ff <= nxt_valley;
        end
    end

    assign switchDriveOut = drive_ff;
    assign valleyEventOut = valley_ff;
    assign rampReference = ramp_ff;
    assign softStartActive = softStart_ff;
    assign latchedOff = (state_ff == ST_LATCHED);

    // Checks
    sequence s_steadyWait;
        !softStart_ff && timeout_ff == STEADY_LIMIT && !demagRise;
    endsequence

    property p_steady_timeout;
        @(posedge clock) disable iff (!reset_n)
        s_steadyWait |=> valleyEventOut;
    endproperty
    a_steady_timeout: assert property (p_steady_timeout) else $error("steady timeout missed");

    property p_startup_timeout;
        @(posedge clock) disable iff (!reset_n)
        (softStart_ff && !demagRise && timeout_ff < STARTUP_LIMIT) |=> !valleyEventOut;
    endproperty
    a_startup_timeout: assert property (p_startup_timeout) else $error("early soft-start timeout");

    property p_timeout_substitute;
        @(posedge clock) disable iff (!reset_n)
        (state_ff == ST_OFF && timeoutHit && overload_ff != OVERLOAD_LIMIT && !syncVec[BIT_OTP]
         && !severeHit) |=> switchDriveOut;
    endproperty
    a_timeout_substitute: assert property (p_timeout_substitute) else $error("timeout did not start pulse");

    sequence s_turnOn;
        !switchDriveOut ##1 switchDriveOut;
    endsequence

    // Protection overrides may cut a pulse at any time, so latch and hiccup entry are let through
    property p_blanking;
        @(posedge clock) disable iff (!reset_n)
        (switchDriveOut && onCount_ff < LEB1 && !syncVec[BIT_SEVERE])
        |=> (switchDriveOut || latchedOff || state_ff == ST_HICCUP);
    endproperty
    a_blanking: assert property (p_blanking) else $error("pulse ended inside blanking");

    property p_short_blank;
        @(posedge clock) disable iff (!reset_n)
        s_turnOn |-> (switchDriveOut || latchedOff || state_ff == ST_HICCUP) [*7];
    endproperty
    a_short_blank: assert property (p_short_blank) else $error("pulse ended inside short blanking");

    property p_pwm_end;
        @(posedge clock) disable iff (!reset_n)
        (state_ff == ST_ON && onCount_ff >= LEB1 && syncVec[BIT_PWM]) |=> !switchDriveOut;
    endproperty
    a_pwm_end: assert property (p_pwm_end) else $error("PWM trip did not end pulse");

    property p_pwm_priority;
        @(posedge clock) disable iff (!reset_n)
        endPwm |=> !overloadSeen_ff;
    endproperty
    a_pwm_priority: assert property (p_pwm_priority) else $error("overload counted on PWM end");

    property p_overload_down;
        @(posedge clock) disable iff (!reset_n)
        (!overloadSeen_ff && overload_ff != '0 && state_ff != ST_HICCUP && state_ff != ST_LATCHED)
        |=> overload_ff == $past(overload_ff) - 1'b1;
    endproperty
    a_overload_down: assert property (p_overload_down) else $error("overload timer not counting down");

    property p_severe_latch;
        @(posedge clock) disable iff (!reset_n)
        (severeHit && severeCount_ff == SEVERE_LIMIT - 3'd1) |=> latchedOff;
    endproperty
    a_severe_latch: assert property (p_severe_latch) else $error("severe count did not latch");

    property p_severe_clear;
        @(posedge clock) disable iff (!reset_n)
        (pulseEnd && !severeHit) |=> severeCount_ff == 3'd0;
    endproperty
    a_severe_clear: assert property (p_severe_clear) else $error("severe count not cleared");

    property p_latch_hold;
        @(posedge clock) disable iff (!reset_n)
        (latchedOff && !syncVec[BIT_BROWN]) |=> latchedOff && !switchDriveOut;
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("latch released without brown-out");
endmodule // qr_flyback_drive
`default_nettype wire

// File: flyback_plant.sv
// Behavioural comparators and switch current seen from the drive output.
// Assumes trip points are set by the bench in on-cycles (1000 = never).
`timescale 1ns/10ps
`default_nettype none
module flyback_plant (
    input wire logic clock,          // Core clock
    input wire logic switchDriveOut, // Drive from the design
    input var int pwmAt,             // On-cycle of PWM trip
    input var int peakAt,            // On-cycle of peak trip
    input var int severeAt,          // On-cycle of severe trip
    input var int demagAt,           // Off-cycle of demag, 0 none
    output logic pwmTripIn,          // PWM comparator
    output logic peakTripIn,         // Peak comparator
    output logic severeTripIn,       // Severe comparator
    output logic rampTripIn,         // Ramp comparator
    output logic demagDetectIn       // Demag comparator
);
    int onCnt = 0;
    int offCnt = 0;
    initial begin
        {pwmTripIn, peakTripIn, severeTripIn, rampTripIn, demagDetectIn} = 5'h00;
    end
    // Sense current exists only while the switch conducts, so trips drop at turn-off
    always @(negedge clock) begin
        onCnt <= switchDriveOut ? onCnt + 1 : 0;
        offCnt <= switchDriveOut ? 0 : offCnt + 1;
        pwmTripIn <= switchDriveOut && onCnt >= pwmAt;
        peakTripIn <= switchDriveOut && onCnt >= peakAt;
        severeTripIn <= switchDriveOut && onCnt >= severeAt;
        rampTripIn <= switchDriveOut && onCnt >= pwmAt;
        demagDetectIn <= demagAt != 0 && !switchDriveOut && offCnt >= demagAt && offCnt < demagAt + 4;
    end
endmodule // flyback_plant
`default_nettype wire

// File: testbench.sv
// Self-checking bench for the flyback drive and protection logic.
// Assumes the latching build, an auto-recovery build beside it, and the shortened timer parameters set below.
`timescale 1ns/10ps
`default_nettype none
`define CHECK(got, exp) begin nTests++; if ((got) !== (exp)) begin failCount++; \
    $display("BAD t=%0t got=%h exp=%h", $time, got, exp); end end
module testbench;
    import qr_flyback_pkg::*;
    localparam int STARTUP = 40;
    localparam int EXPIRY = 64;
    localparam int RAMP = 512;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic overTempIn = 1'b0;
    logic brownOutIn = 1'b0;
    logic hiccupDoneIn = 1'b0;
    logic pwm2, peak2, severe2, ramp2, demag2, drive2, soft2, latched2;
    logic [RAMP_WIDTH-1:0] ramp2Ref;
    logic pwmTripIn, peakTripIn, severeTripIn, rampTripIn, demagDetectIn;
    logic switchDriveOut, valleyEventOut, softStartActive, latchedOff;
    logic [RAMP_WIDTH-1:0] rampReference;
    int pwmAt = 20, peakAt = 1000, severeAt = 1000, demagAt = 0;
    int failCount = 0, nTests = 0, cyc = 0, relStart = 0;
    always #10 clock = ~clock;
    qr_flyback_drive #(.STARTUP_TIMEOUT(STARTUP), .OVERLOAD_EXPIRY(EXPIRY), .RAMP_DURATION(RAMP),
        .LATCH_ON_OVERLOAD(1'b1)) i_qr_flyback_drive (.clock(clock), .reset_n(reset_n),
        .demagDetectIn(demagDetectIn), .pwmTripIn(pwmTripIn), .peakTripIn(peakTripIn),
        .severeTripIn(severeTripIn), .rampTripIn(rampTripIn), .overTempIn(overTempIn),
        .brownOutIn(brownOutIn), .hiccupDoneIn(hiccupDoneIn), .switchDriveOut(switchDriveOut),
        .valleyEventOut(valleyEventOut), .rampReference(rampReference),
        .softStartActive(softStartActive), .latchedOff(latchedOff));
    flyback_plant i_flyback_plant (.clock(clock), .switchDriveOut(switchDriveOut), .pwmAt(pwmAt),
        .peakAt(peakAt), .severeAt(severeAt), .demagAt(demagAt), .pwmTripIn(pwmTripIn),
        .peakTripIn(peakTripIn), .severeTripIn(severeTripIn), .rampTripIn(rampTripIn),
        .demagDetectIn(demagDetectIn));
    // Auto-recovery build on its own plant; peak-only trips make its overload timer expire early
    qr_flyback_drive #(.STARTUP_TIMEOUT(STARTUP), .OVERLOAD_EXPIRY(EXPIRY), .RAMP_DURATION(RAMP),
        .LATCH_ON_OVERLOAD(1'b0)) i_qr_flyback_drive_auto (.clock(clock), .reset_n(reset_n),
        .demagDetectIn(demag2), .pwmTripIn(pwm2), .peakTripIn(peak2), .severeTripIn(severe2),
        .rampTripIn(ramp2), .overTempIn(overTempIn), .brownOutIn(brownOutIn),
        .hiccupDoneIn(hiccupDoneIn), .switchDriveOut(drive2), .valleyEventOut(),
        .rampReference(ramp2Ref), .softStartActive(soft2), .latchedOff(latched2));
    flyback_plant i_flyback_plant_auto (.clock(clock), .switchDriveOut(drive2), .pwmAt(1000),
        .peakAt(20), .severeAt(1000), .demagAt(30), .pwmTripIn(pwm2), .peakTripIn(peak2),
        .severeTripIn(severe2), .rampTripIn(ramp2), .demagDetectIn(demag2));
    task automatic wrapUp;
        $display("Checks %0d, mismatches %0d", nTests, failCount);
        if (failCount == 0 && nTests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Ceiling sits well above the sum of all scenarios
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            failCount = failCount + 1;
            wrapUp();
        end
    end
    task automatic cycles(input int n);
        repeat (n) @(negedge clock);
    endtask
    task automatic gap(output int g);
        int k;
        g = 1;
        k = 0;
        while (valleyEventOut !== 1'b1 && k < 3000) begin @(negedge clock); k++; end
        @(negedge clock);
        while (valleyEventOut !== 1'b1 && g < 3000) begin @(negedge clock); g++; end
    endtask
    task automatic pulse(output int n);
        int k;
        n = 0;
        k = 0;
        while (switchDriveOut !== 1'b1 && k < 3000) begin @(negedge clock); k++; end
        while (switchDriveOut === 1'b1 && n < 3000) begin @(negedge clock); n++; end
    endtask
    task automatic quiet(output int h);
        h = 0;
        repeat (400) begin @(negedge clock); if (switchDriveOut !== 1'b0) h++; end
    endtask
    task automatic softEnd;
        int k;
        k = 0;
        while (softStartActive !== 1'b0 && k < 2000) begin @(negedge clock); k++; end
    endtask
    task automatic clearLatch;
        brownOutIn = 1'b1;
        cycles(10);
        brownOutIn = 1'b0;
        cycles(10);
        `CHECK(latchedOff, 1'b0)
    endtask
    task automatic tStartup;
        int g;
        gap(g);
        `CHECK(g inside {[STARTUP:STARTUP + 40]}, 1'b1)
        `CHECK(rampReference inside {[8'h01:8'hfe]}, 1'b1)
        softEnd();
        `CHECK((cyc - relStart) inside {[RAMP - 20:RAMP + 20]}, 1'b1)
        `CHECK(rampReference, PEAK_THRESHOLD_CODE)
        gap(g);
        gap(g);
        `CHECK(g inside {[STEADY_TIMEOUT_CYC:STEADY_TIMEOUT_CYC + 40]}, 1'b1)
    endtask
    task automatic tDemagBlank;
        int n;
        demagAt = 30;
        gap(n);
        gap(n);
        `CHECK(n inside {[30:120]}, 1'b1)
        pwmAt = 0;
        pulse(n);
        pulse(n);
        `CHECK(n inside {[PRIMARY_BLANK_CYC:PRIMARY_BLANK_CYC + 6]}, 1'b1)
        pwmAt = 30;
        pulse(n);
        pulse(n);
        `CHECK(n inside {[30:38]}, 1'b1)
    endtask
    task automatic tSevere;
        int n;
        pwmAt = 40;
        severeAt = 0;
        repeat (3) pulse(n);
        `CHECK(n inside {[SHORT_BLANK_CYC:SHORT_BLANK_CYC + 6]}, 1'b1)
        severeAt = 1000;
        pulse(n);
        severeAt = 0;
        repeat (3) pulse(n);
        `CHECK(latchedOff, 1'b0)
        pulse(n);
        cycles(5);
        `CHECK(latchedOff, 1'b1)
        quiet(n);
        `CHECK(n, 0)
        `CHECK(latchedOff, 1'b1)
        severeAt = 1000;
        clearLatch();
    endtask
    task automatic tOverload;
        int n;
        softEnd();
        pwmAt = 5;
        peakAt = 5;
        repeat (10) pulse(n);
        `CHECK(latchedOff, 1'b0)
        pwmAt = 1000;
        peakAt = 20;
        pulse(n);
        `CHECK(n inside {[20:28]}, 1'b1)
        n = 0;
        while (latchedOff !== 1'b1 && n < 400) begin @(negedge clock); n++; end
        `CHECK(n inside {[EXPIRY - 4:EXPIRY + 20]}, 1'b1)
        quiet(n);
        `CHECK(n, 0)
        pwmAt = 20;
        peakAt = 1000;
        clearLatch();
    endtask
    task automatic tOverTemp;
        overTempIn = 1'b1;
        cycles(100);
        `CHECK(softStartActive, 1'b1)
        `CHECK(latchedOff, 1'b0)
        softEnd();
        cycles(10);
        `CHECK(latchedOff, 1'b1)
        overTempIn = 1'b0;
    endtask
    task automatic tHiccup;
        int n;
        `CHECK(drive2, 1'b0)
        `CHECK(latched2, 1'b0)
        repeat (2) begin
            hiccupDoneIn = 1'b1;
            cycles(4);
            hiccupDoneIn = 1'b0;
            cycles(4);
        end
        n = 0;
        repeat (100) begin @(negedge clock); if (drive2 !== 1'b0) n++; end
        `CHECK(n, 0)
        hiccupDoneIn = 1'b1;
        cycles(4);
        hiccupDoneIn = 1'b0;
        `CHECK(soft2, 1'b1)
        `CHECK(ramp2Ref, RAMP_RESET)
        n = 0;
        while (drive2 !== 1'b1 && n < 200) begin @(negedge clock); n++; end
        `CHECK(n < 200, 1'b1)
    endtask
    initial begin
        cycles(6);
        `CHECK(switchDriveOut, 1'b0)
        `CHECK(rampReference, RAMP_RESET)
        `CHECK(softStartActive, 1'b1)
        `CHECK(latchedOff, 1'b0)
        reset_n = 1'b1;
        relStart = cyc;
        tStartup();
        tDemagBlank();
        tSevere();
        tOverload();
        tOverTemp();
        tHiccup();
        wrapUp();
    end
endmodule // testbench
`default_nettype wire
